// ### shared/eeprom_slave_regs.svh
// Constants for the two-wire serial memory slave
`ifndef EEPROM_SLAVE_REGS_SVH
`define EEPROM_SLAVE_REGS_SVH

// Pin vector positions inside the input synchroniser
`define PIN_SCL            0
`define PIN_SDA            1
`define PIN_STRAP_LO       2
`define PIN_STRAP_HI       3
`define PIN_WP             4
`define PIN_COUNT          5

// Select byte layout
`define SEL_TYPE_HI        7
`define SEL_TYPE_LO        4
`define SEL_STRAP_HI_BIT   3
`define SEL_STRAP_LO_BIT   2
`define SEL_ADDR_TOP_BIT   1
`define SEL_RW_BIT         0

// Bit slot numbering within one byte plus its acknowledge
`define FIRST_SLOT         4'h0
`define LAST_DATA_BIT      4'h7
`define ACK_SLOT           4'h8

// Address space
`define ADDR_RESET         9'h000
`define UPPER_HALF_BIT     8
`define PAGE_BYTES         16

// Internal write cycle
`define WRITE_CYCLE_TIME_US 5
`define CLOCK_MHZ          50

`endif

// ### shared/eeprom_slave_pkg.sv
// Types shared by the two-wire serial memory slave
package eeprom_slave_pkg;

    typedef logic [8:0] mem_addr_t;
    typedef logic [7:0] mem_byte_t;
    typedef logic [3:0] slot_t;

    typedef enum logic [2:0] {
        S_IDLE,
        S_SELECT,
        S_ADDR,
        S_WDATA,
        S_RDATA,
        S_BUSY
    } slave_state_e;

endpackage : eeprom_slave_pkg

// ### hdl/i2c_eeprom_slave_upper_protect.sv
// Two-wire serial memory slave with upper-half write protection
`timescale 1ns/1ps

`include "eeprom_slave_regs.svh"

module i2c_eeprom_slave_upper_protect
    import eeprom_slave_pkg::*;
#(
    // Arbitrary neutral value, set to the fitted memory type code
    parameter logic [3:0] DEVICE_TYPE_ID   = 4'h5,
    parameter int         WRITE_CYCLE_CLKS =
        `WRITE_CYCLE_TIME_US * `CLOCK_MHZ
) (
    // Clock and reset
    input  wire logic      clock,
    input  wire logic      rst,
    input  wire logic      por_active,
    // Serial bus
    input  wire logic      scl_in,
    input  wire logic      sda_in,
    output wire logic      sda_out,
    output wire logic      sda_oe_n,
    // Straps and protection
    input  wire logic      chip_sel_strap_hi,
    input  wire logic      chip_sel_strap_lo,
    input  wire logic      upper_half_write_protect,
    // Memory array side
    output wire mem_addr_t mem_rd_addr,
    input  wire mem_byte_t mem_rd_data,
    output logic           prog_we,
    output mem_addr_t      prog_addr,
    output mem_byte_t      prog_data,
    output wire logic      write_busy
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [`PIN_COUNT-1:0] pin_s1_r;
    logic [`PIN_COUNT-1:0] pin_s2_r;
    logic [`PIN_COUNT-1:0] pin_s3_r;
    logic [`PIN_COUNT-1:0] pin_f_r;
    logic                  scl_prev_r;
    logic                  sda_prev_r;
    slave_state_e          state_r;
    slot_t                 bit_cnt_r;
    logic                  got_rise_r;
    logic                  ten_slot_r;
    mem_byte_t             shift_r;
    mem_byte_t             tx_r;
    logic                  drive_r;
    logic                  wp_seen_r;
    mem_addr_t             addr_r;
    mem_byte_t             page_mem [`PAGE_BYTES];
    logic [`PAGE_BYTES-1:0] page_vld_r;
    logic [31:0]           busy_cnt_r;

    logic hold;
    logic scl_f;
    logic sda_f;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic slot_end;
    logic byte_done;
    logic ack_end;
    logic ack_rise;
    logic sel_match;
    logic prot;
    logic busy_done;

    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    // A pin level counts once the second and third stages agree
    always_ff @(posedge clock) begin
        pin_s1_r <= {upper_half_write_protect, chip_sel_strap_hi,
                     chip_sel_strap_lo, sda_in, scl_in};
        pin_s2_r <= pin_s1_r;
        pin_s3_r <= pin_s2_r;
        pin_f_r  <= (~(pin_s2_r ^ pin_s3_r) & pin_s2_r)
                  | ((pin_s2_r ^ pin_s3_r) & pin_f_r);
        scl_prev_r <= pin_f_r[`PIN_SCL];
        sda_prev_r <= pin_f_r[`PIN_SDA];
    end

    // ------------------------------------------------------------
    // Bus events
    // ------------------------------------------------------------
    // power-on hold
    assign hold     = rst | por_active;
    assign scl_f    = pin_f_r[`PIN_SCL];
    assign sda_f    = pin_f_r[`PIN_SDA];
    assign scl_rise = scl_f & ~scl_prev_r;
    assign scl_fall = ~scl_f & scl_prev_r;
    assign start_det = scl_f & scl_prev_r & sda_prev_r & ~sda_f;
    assign stop_det  = scl_f & scl_prev_r & ~sda_prev_r & sda_f;
    assign slot_end  = scl_fall & got_rise_r;
    assign byte_done = slot_end & (bit_cnt_r == `LAST_DATA_BIT);
    assign ack_end   = slot_end & (bit_cnt_r == `ACK_SLOT);
    assign ack_rise  = scl_rise & (bit_cnt_r == `ACK_SLOT);

    assign sel_match =
        (shift_r[`SEL_TYPE_HI:`SEL_TYPE_LO] == DEVICE_TYPE_ID)
        && (shift_r[`SEL_STRAP_HI_BIT] == pin_f_r[`PIN_STRAP_HI])
        && (shift_r[`SEL_STRAP_LO_BIT] == pin_f_r[`PIN_STRAP_LO]);

    assign prot      = wp_seen_r & addr_r[`UPPER_HALF_BIT];
    assign busy_done = (state_r == S_BUSY)
                     && (busy_cnt_r == 32'(WRITE_CYCLE_CLKS - 1));

    // ------------------------------------------------------------
    // Transaction sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (hold) begin
            state_r    <= S_IDLE;
            bit_cnt_r  <= `FIRST_SLOT;
            got_rise_r <= 1'b0;
            ten_slot_r <= 1'b0;
        end else if (state_r == S_BUSY) begin
            if (busy_done) begin
                state_r <= S_IDLE;
            end
        end else if (start_det) begin
            state_r    <= S_SELECT;
            bit_cnt_r  <= `FIRST_SLOT;
            got_rise_r <= 1'b0;
            ten_slot_r <= 1'b0;
        end else if (stop_det) begin
            state_r    <= (ten_slot_r && state_r == S_WDATA)
                        ? S_BUSY : S_IDLE;
            ten_slot_r <= 1'b0;
        end else if (state_r != S_IDLE) begin
            if (scl_rise) begin
                got_rise_r <= 1'b1;
                if (ack_rise && state_r == S_RDATA && sda_f) begin
                    state_r <= S_IDLE;
                end
            end
            if (slot_end) begin
                got_rise_r <= 1'b0;
                // Stop comes after the tenth rise, so only a fall closes it
                ten_slot_r <= 1'b0;
                bit_cnt_r  <= (bit_cnt_r == `ACK_SLOT)
                            ? `FIRST_SLOT : bit_cnt_r + 4'h1;
            end
            if (byte_done && state_r == S_SELECT && !sel_match) begin
                state_r <= S_IDLE;
            end
            if (ack_end) begin
                unique case (state_r)
                    S_SELECT: state_r <= shift_r[`SEL_RW_BIT]
                                       ? S_RDATA : S_ADDR;
                    S_ADDR:   state_r <= S_WDATA;
                    S_WDATA:  ten_slot_r <= !prot;
                    S_RDATA:  state_r <= S_RDATA;
                    S_IDLE, S_BUSY: state_r <= state_r;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Receive shifter
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (hold) begin
            shift_r <= 8'h00;
        end else if (scl_rise && bit_cnt_r != `ACK_SLOT
                     && state_r != S_IDLE && state_r != S_BUSY) begin
            shift_r <= {shift_r[6:0], sda_f};
        end
    end

    // ------------------------------------------------------------
    // Data line driver
    // ------------------------------------------------------------
    // Only ever pulls low; a released line is high through the pull-up
    always_ff @(posedge clock) begin
        if (hold || start_det || stop_det
            || state_r == S_IDLE || state_r == S_BUSY) begin
            drive_r <= 1'b0;
        end else if (byte_done) begin
            drive_r <= (state_r == S_SELECT && sel_match)
                     || state_r == S_ADDR
                     || (state_r == S_WDATA && !prot);
        end else if (ack_end) begin
            drive_r <= ((state_r == S_SELECT && shift_r[`SEL_RW_BIT])
                        || state_r == S_RDATA) && !mem_rd_data[7];
        end else if (slot_end && state_r == S_RDATA) begin
            drive_r <= !tx_r[6];
        end
    end

    always_ff @(posedge clock) begin
        if (hold) begin
            tx_r <= 8'h00;
        end else if (ack_end) begin
            tx_r <= mem_rd_data;
        end else if (slot_end && state_r == S_RDATA) begin
            tx_r <= {tx_r[6:0], 1'b0};
        end
    end

    // ------------------------------------------------------------
    // Write protect sampling
    // ------------------------------------------------------------
    // sample start to address end
    // only a high level protects
    // An unconnected pin needs the pad pull-down to read low here
    always_ff @(posedge clock) begin
        if (hold) begin
            wp_seen_r <= 1'b0;
        end else if (start_det && state_r != S_BUSY) begin
            wp_seen_r <= pin_f_r[`PIN_WP];
        end else if ((state_r == S_SELECT || state_r == S_ADDR)
                     && bit_cnt_r != `ACK_SLOT) begin
            wp_seen_r <= wp_seen_r | pin_f_r[`PIN_WP];
        end
    end

    // ------------------------------------------------------------
    // Address counter
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (hold) begin
            addr_r <= `ADDR_RESET;
        end else if (byte_done) begin
            unique case (state_r)
                S_SELECT: if (sel_match) begin
                    addr_r[`UPPER_HALF_BIT] <= shift_r[`SEL_ADDR_TOP_BIT];
                end
                S_ADDR:   addr_r[7:0] <= shift_r;
                S_WDATA:  if (!prot) begin
                    addr_r[3:0] <= addr_r[3:0] + 4'h1;
                end
                S_RDATA:  addr_r <= addr_r + 9'h001;
                S_IDLE, S_BUSY: addr_r <= addr_r;
            endcase
        end
    end

    assign mem_rd_addr = addr_r;

    // ------------------------------------------------------------
    // Page latches
    // ------------------------------------------------------------
    // Bytes beyond the page end roll over and replace earlier ones
    always_ff @(posedge clock) begin
        if (byte_done && state_r == S_WDATA && !prot) begin
            page_mem[addr_r[3:0]] <= shift_r;
        end
    end

    always_ff @(posedge clock) begin
        if (hold || busy_done) begin
            page_vld_r <= '0;
        end else if (byte_done && state_r == S_ADDR) begin
            page_vld_r <= '0;
        end else if (byte_done && state_r == S_WDATA && !prot) begin
            page_vld_r[addr_r[3:0]] <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Internal write cycle
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (hold || state_r != S_BUSY) begin
            busy_cnt_r <= 32'h0;
        end else begin
            busy_cnt_r <= busy_cnt_r + 32'h1;
        end
    end

    // Latched bytes are handed to the array in the first cycles
    always_ff @(posedge clock) begin
        if (hold) begin
            prog_we   <= 1'b0;
            prog_addr <= `ADDR_RESET;
            prog_data <= 8'h00;
        end else begin
            prog_we   <= (state_r == S_BUSY)
                       && (busy_cnt_r < 32'(`PAGE_BYTES))
                       && page_vld_r[busy_cnt_r[3:0]];
            prog_addr <= {addr_r[8:4], busy_cnt_r[3:0]};
            prog_data <= page_mem[busy_cnt_r[3:0]];
        end
    end

    assign write_busy = (state_r == S_BUSY);
    assign sda_out    = 1'b0;
    assign sda_oe_n   = ~drive_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (hold);

    property p_busy_quiet;
        state_r == S_BUSY |-> sda_oe_n;
    endproperty
    a_busy_quiet: assert property (p_busy_quiet)
        else $error("data line driven during write cycle");

    property p_por;
        @(posedge clock) disable iff (rst)
        por_active |=> state_r == S_IDLE && sda_oe_n;
    endproperty
    a_por: assert property (p_por)
        else $error("bus not ignored during power-on reset");

    property p_start;
        start_det && state_r != S_BUSY
        |=> state_r == S_SELECT && bit_cnt_r == `FIRST_SLOT;
    endproperty
    a_start: assert property (p_start)
        else $error("start not taken");

    property p_stop;
        stop_det && state_r != S_BUSY
        && !(ten_slot_r && state_r == S_WDATA) |=> state_r == S_IDLE;
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop did not end exchange");

    property p_launch;
        $rose(state_r == S_BUSY) |-> $past(ten_slot_r)
        && $past(stop_det) && !prog_we;
    endproperty
    a_launch: assert property (p_launch)
        else $error("write cycle launched outside tenth slot");

    property p_prot_nack;
        state_r == S_WDATA && prot && bit_cnt_r == `ACK_SLOT
        |-> sda_oe_n;
    endproperty
    a_prot_nack: assert property (p_prot_nack)
        else $error("protected data byte acknowledged");

    property p_prot_keep;
        state_r == S_WDATA && prot |-> page_vld_r == '0;
    endproperty
    a_prot_keep: assert property (p_prot_keep)
        else $error("protected byte latched for programming");

    property p_sel_ack;
        byte_done && state_r == S_SELECT && sel_match
        |=> !sda_oe_n ##1 !sda_oe_n;
    endproperty
    a_sel_ack: assert property (p_sel_ack)
        else $error("matching select not acknowledged");

    property p_mismatch;
        byte_done && state_r == S_SELECT && !sel_match
        |=> state_r == S_IDLE && sda_oe_n;
    endproperty
    a_mismatch: assert property (p_mismatch)
        else $error("mismatched select not dropped");

    property p_rd_nack;
        ack_rise && state_r == S_RDATA && sda_f |=> state_r == S_IDLE;
    endproperty
    a_rd_nack: assert property (p_rd_nack)
        else $error("read continued after master nack");

    property p_rd_inc;
        byte_done && state_r == S_RDATA
        |=> addr_r == $past(addr_r) + 9'h001;
    endproperty
    a_rd_inc: assert property (p_rd_inc)
        else $error("read address not advanced");

    property p_page;
        byte_done && state_r == S_WDATA && !prot
        |=> addr_r[8:4] == $past(addr_r[8:4]);
    endproperty
    a_page: assert property (p_page)
        else $error("page write left its page");

    property p_capture;
        scl_rise && state_r == S_ADDR && bit_cnt_r != `ACK_SLOT
        && !start_det |=> shift_r[0] == $past(sda_f);
    endproperty
    a_capture: assert property (p_capture)
        else $error("bit not captured on rising clock");

    c_write_cycle: cover property ($rose(state_r == S_BUSY));
    c_prot_write:  cover property (ack_end && state_r == S_WDATA && prot);
    c_seq_read:    cover property (ack_end && state_r == S_RDATA);
    c_read_nack:   cover property (ack_rise && state_r == S_RDATA && sda_f);

endmodule : i2c_eeprom_slave_upper_protect

// ### dv/i2c_master_model.sv
// Bus master model: drives the serial clock and pulls the data line
`timescale 1ns/1ps

module i2c_master_model (
    // Bus lines
    output logic      scl,
    output logic      sda_m,
    input  wire logic sda
);
    // Quarter of the 160 ns bus clock period
    localparam int QTR = 40;

    // Clock stands high and data is released between frames
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end

    // Data moves while low
    // Low 120 ns, high 40 ns: the slave answers about 100 ns after
    // the falling edge, so its bit must settle before the rise
    task automatic bit_x(input logic b, output logic r);
        scl = 1'b0;
        #QTR sda_m = b;
        #(2*QTR) scl = 1'b1;
        #QTR r = sda;
    endtask : bit_x

    task automatic start();
        scl = 1'b0;
        #QTR sda_m = 1'b1;
        // Long low phase lets a slave acknowledge release first
        #(2*QTR) scl = 1'b1;
        #(2*QTR) sda_m = 1'b0;
        #(2*QTR);
    endtask : start

    task automatic stop();
        scl = 1'b0;
        #QTR sda_m = 1'b0;
        #(2*QTR) scl = 1'b1;
        #(2*QTR) sda_m = 1'b1;
        #(4*QTR);
    endtask : stop

    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r);
        end
        bit_x(1'b1, r);
        ack = ~r;
    endtask : wbyte

    task automatic rbyte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, r);
            d[i] = r;
        end
        bit_x(~ack, r);
    endtask : rbyte
endmodule : i2c_master_model

// ### dv/testbench.sv
// Self-checking bench for the two-wire serial memory slave
`timescale 1ns/1ps

module testbench
    import eeprom_slave_pkg::*;
;
    localparam int         WCC = 120;
    // Arbitrary type code, not a real one
    localparam logic [3:0] TID = 4'h6;
    localparam logic [7:0] SEL = {TID, 4'b1000};

    logic      clock = 1'b0;
    logic      rst = 1'b1;
    logic      por_active = 1'b0;
    logic      wp = 1'b0;
    logic      scl;
    logic      sda_m;
    wire logic sda;
    logic      sda_out;
    logic      sda_oe_n;
    mem_addr_t mem_rd_addr;
    mem_byte_t mem_rd_data;
    logic      prog_we;
    mem_addr_t prog_addr;
    mem_byte_t prog_data;
    logic      write_busy;
    mem_byte_t mem [512];
    mem_byte_t exp [512];
    int        busy_n = 0;
    int        n_fail = 0;
    int        n_compared = 0;
    logic      ack;
    logic [7:0] b;

    always #10 clock = ~clock;

    // Open-drain data wire with pull-up
    assign sda = sda_m & (sda_oe_n | sda_out);
    assign mem_rd_data = mem[mem_rd_addr];

    always @(posedge clock) begin
        if (prog_we) begin
            mem[prog_addr] <= prog_data;
        end
        if (write_busy) begin
            busy_n <= busy_n + 1;
        end
    end

    i2c_master_model master_u (.scl(scl), .sda_m(sda_m), .sda(sda));

    i2c_eeprom_slave_upper_protect #(
        .DEVICE_TYPE_ID  (TID),
        .WRITE_CYCLE_CLKS(WCC)
    ) dut_u (
        .clock(clock), .rst(rst), .por_active(por_active),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .chip_sel_strap_hi(1'b1),
        .chip_sel_strap_lo(1'b0), .upper_half_write_protect(wp),
        .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data),
        .prog_we(prog_we), .prog_addr(prog_addr),
        .prog_data(prog_data), .write_busy(write_busy)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #3;
    endtask : tick

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            $display("[FAIL] %0t got %0h exp %0h", $time, g, e);
            n_fail++;
        end
    endtask : chk

    task automatic end_sim();
        $display("Compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim

    task automatic wr(input mem_addr_t a, input int n, input logic xa);
        logic r;
        master_u.start();
        master_u.wbyte({TID, 2'b10, a[8], 1'b0}, r);
        chk(r, 1'b1);
        master_u.wbyte(a[7:0], r);
        chk(r, 1'b1);
        for (int i = 0; i < n; i++) begin
            master_u.wbyte(a[7:0] ^ 8'h3c, r);
            chk(r, xa);
            if (xa) begin
                exp[a] = a[7:0] ^ 8'h3c;
            end
            a[3:0] = a[3:0] + 4'h1;
        end
        busy_n = 0;
        master_u.stop();
    endtask : wr

    task automatic wait_wc(input int xn);
        int k;
        k = 0;
        tick(12);
        while (write_busy === 1'b1 && k < 1000) begin
            tick(1);
            k++;
        end
        if (k >= 1000) begin
            n_fail++;
            end_sim();
        end
        chk(busy_n, xn);
    endtask : wait_wc

    task automatic rd(input mem_addr_t a, input int n);
        logic [7:0] d;
        for (int i = 0; i < n; i++) begin
            master_u.rbyte(i < n - 1, d);
            chk(d, exp[a]);
            a = a + 9'h001;
        end
        master_u.stop();
        chk(sda_oe_n, 1'b1);
    endtask : rd

    task automatic sel(input logic [7:0] s, input logic xa);
        master_u.start();
        master_u.wbyte(s, ack);
        chk(ack, xa);
    endtask : sel

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        for (int i = 0; i < 512; i++) begin
            mem[i] = 8'(i) ^ 8'ha5;
            exp[i] = 8'(i) ^ 8'ha5;
        end
        tick(12);
        rst = 1'b0;
        tick(6);
        chk({sda_oe_n, write_busy, mem_rd_addr}, 11'h400);
        master_u.wbyte(SEL, ack);
        chk(ack, 1'b0);
        master_u.stop();
        for (int s = 0; s < 5; s++) begin
            b = (s < 4) ? {TID, 2'(s), 2'b00} : {~TID, 4'b1000};
            sel(b, b == SEL);
            master_u.stop();
        end
        wait_wc(0);
        wr(9'h1fd, 3, 1'b1);
        tick(12);
        sel(SEL, 1'b0);
        master_u.stop();
        wait_wc(WCC);
        wp = 1'b1;
        wr(9'h0fe, 3, 1'b1);
        wait_wc(WCC);
        wr(9'h120, 2, 1'b0);
        wait_wc(0);
        wp = 1'b0;
        sel({TID, 4'b1010}, 1'b1);
        master_u.wbyte(8'hfe, ack);
        chk(ack, 1'b1);
        sel({TID, 4'b1011}, 1'b1);
        rd(9'h1fe, 4);
        sel({TID, 4'b1001}, 1'b1);
        rd(9'h002, 1);
        por_active = 1'b1;
        sel(SEL, 1'b0);
        master_u.stop();
        por_active = 1'b0;
        tick(6);
        chk(mem_rd_addr, 9'h000);
        sel(SEL, 1'b1);
        master_u.stop();
        for (int i = 0; i < 512; i++) begin
            chk(mem[i], exp[i]);
        end
        end_sim();
    end
endmodule : testbench
